/* dpsf_map.svh */
// Purpose: constants for the semaphore flag port controller
// Assumes: one port of the flag device, 8-bit data bus
// Notes:   strobe widths are cycles of ref_clk_i
`ifndef DPSF_MAP_SVH
`define DPSF_MAP_SVH
`define DPSF_NUM_FLAGS    8
`define DPSF_IDX_W        3
`define DPSF_ADDR_W       13
`define DPSF_DATA_W       8
`define DPSF_STROBE_NS    100
`define DPSF_CLK_NS       50
`define DPSF_STROBE_CYC   ((`DPSF_STROBE_NS + `DPSF_CLK_NS - 1) / `DPSF_CLK_NS)
`define DPSF_CNT_W        4
`define DPSF_ALL_ONES     8'hff
`define DPSF_ZERO_BYTE    8'h00
`endif

/* dpsf_pkg.sv */
// Purpose: types for the semaphore flag port controller
// Assumes: nothing beyond the map header
// Notes:   commands issued on cmd_op_i
package dpsf_pkg;
  typedef enum logic [2:0] {
    DPSF_OP_ACQUIRE = 3'h0,
    DPSF_OP_RELEASE = 3'h1,
    DPSF_OP_POLL    = 3'h2,
    DPSF_OP_INIT    = 3'h3
  } dpsf_op_type;
  typedef enum logic [5:0] {
    DPSF_ST_IDLE  = 6'h01,
    DPSF_ST_WSET  = 6'h02,
    DPSF_ST_WSTB  = 6'h04,
    DPSF_ST_RSET  = 6'h08,
    DPSF_ST_RSTB  = 6'h10,
    DPSF_ST_GAP   = 6'h20
  } dpsf_state_type;
endpackage : dpsf_pkg

/* dpsf_timer.sv */
// Purpose: strobe width timer
// Assumes: load and count in one clock domain
// Notes:   done is combinational from the count
`timescale 1ns/100ps
`include "dpsf_map.svh"
module dpsf_timer (
  // clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   resetn_i,
  // control
  input  wire logic                   load_i,
  output logic                        done_o
);
  logic [`DPSF_CNT_W-1:0] cnt_reg;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= '0;
    end else if (load_i) begin
      cnt_reg <= `DPSF_CNT_W'(`DPSF_STROBE_CYC);
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - `DPSF_CNT_W'(1);
    end
  end
  // done ignores load: the load term reads done, so gating it here made a loop
  assign done_o = (cnt_reg == '0);
endmodule : dpsf_timer

/* dpsf_ctrl.sv */
// Summary of operation
// - flags active low: write zero requests, write one releases from same side
// - a polling port deasserts select or oe between reads
// - acquire writes zero first, then reads back to confirm
// - after a failed request keep reading or write one to withdraw
// - at start each port writes one to all eight flags
// - flag access holds memory select high and flag select low
//
// Purpose: one-port controller that drives the flag pins of the device
// Assumes: device pins sampled on ref_clk_i; one command at a time
// Notes:   result of acquire and poll is the inverse of bit zero of the read-back byte
`timescale 1ns/100ps
`include "dpsf_map.svh"
module dpsf_ctrl (
  // clock and reset
  input  wire logic                       ref_clk_i,
  input  wire logic                       resetn_i,
  // command port
  input  wire logic                       cmd_valid_i,
  input  wire dpsf_pkg::dpsf_op_type      cmd_op_i,
  input  wire logic [`DPSF_IDX_W-1:0]     cmd_idx_i,
  output logic                            cmd_ready_o,
  output logic                            rsp_valid_o,
  output logic                            rsp_owned_o,
  // device pins
  output logic                            mem_select_n_o,
  output logic                            flag_space_select_n_o,
  output logic                            rw_n_o,
  output logic                            oe_n_o,
  output logic [`DPSF_ADDR_W-1:0]         addr_o,
  output logic [`DPSF_DATA_W-1:0]         data_o,
  output logic                            data_oe_n_o,
  input  wire logic [`DPSF_DATA_W-1:0]    data_i
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  dpsf_pkg::dpsf_state_type state_reg;
  dpsf_pkg::dpsf_op_type    op_reg;
  logic [`DPSF_IDX_W-1:0]   idx_reg;
  logic                     wval_reg;
  logic                     tmr_load;
  logic                     tmr_done;
  logic                     last_init;

  dpsf_timer u_timer (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .load_i    (tmr_load),
    .done_o    (tmr_done)
  );

  assign cmd_ready_o = (state_reg == dpsf_pkg::DPSF_ST_IDLE);
  assign last_init   = (idx_reg == `DPSF_IDX_W'(`DPSF_NUM_FLAGS - 1));
  // loads timer on entry to each strobe and gap phase
  assign tmr_load    = (state_reg == dpsf_pkg::DPSF_ST_WSET)
                     || (state_reg == dpsf_pkg::DPSF_ST_RSET)
                     || (state_reg == dpsf_pkg::DPSF_ST_RSTB && tmr_done)
                     || (state_reg == dpsf_pkg::DPSF_ST_WSTB && tmr_done
                         && op_reg != dpsf_pkg::DPSF_OP_ACQUIRE);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= dpsf_pkg::DPSF_ST_IDLE;
      op_reg    <= dpsf_pkg::DPSF_OP_POLL;
      idx_reg   <= '0;
      wval_reg  <= 1'b1;
    end else begin
      case (state_reg)
        dpsf_pkg::DPSF_ST_IDLE: begin
          if (cmd_valid_i) begin
            op_reg <= cmd_op_i;
            // init walks all flags from zero
            idx_reg <= (cmd_op_i == dpsf_pkg::DPSF_OP_INIT) ? '0 : cmd_idx_i;
            // acquire writes zero, release and init write one
            wval_reg <= (cmd_op_i != dpsf_pkg::DPSF_OP_ACQUIRE);
            // poll is a read only; acquire never reads first
            state_reg <= (cmd_op_i == dpsf_pkg::DPSF_OP_POLL) ?
                         dpsf_pkg::DPSF_ST_RSET : dpsf_pkg::DPSF_ST_WSET;
          end
        end
        dpsf_pkg::DPSF_ST_WSET: begin
          state_reg <= dpsf_pkg::DPSF_ST_WSTB;
        end
        dpsf_pkg::DPSF_ST_WSTB: begin
          if (tmr_done) begin
            // acquire goes straight to its confirming read
            state_reg <= (op_reg == dpsf_pkg::DPSF_OP_ACQUIRE) ?
                         dpsf_pkg::DPSF_ST_RSET : dpsf_pkg::DPSF_ST_GAP;
          end
        end
        dpsf_pkg::DPSF_ST_RSET: begin
          state_reg <= dpsf_pkg::DPSF_ST_RSTB;
        end
        dpsf_pkg::DPSF_ST_RSTB: begin
          if (tmr_done) begin
            state_reg <= dpsf_pkg::DPSF_ST_GAP;
          end
        end
        dpsf_pkg::DPSF_ST_GAP: begin
          // selects idle for a full gap so the next read recaptures
          if (tmr_done) begin
            if (op_reg == dpsf_pkg::DPSF_OP_INIT && !last_init) begin
              idx_reg   <= idx_reg + `DPSF_IDX_W'(1);
              state_reg <= dpsf_pkg::DPSF_ST_WSET;
            end else begin
              state_reg <= dpsf_pkg::DPSF_ST_IDLE;
            end
          end
        end
        default: begin
          state_reg <= dpsf_pkg::DPSF_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_select_n_o        <= 1'b1;
      flag_space_select_n_o <= 1'b1;
      rw_n_o                <= 1'b1;
      oe_n_o                <= 1'b1;
      addr_o                <= '0;
      data_o                <= `DPSF_ALL_ONES;
      data_oe_n_o           <= 1'b1;
    end else begin
      // memory select never asserted by this block
      mem_select_n_o <= 1'b1;
      // flag select low through setup and strobe
      flag_space_select_n_o <= !(state_reg == dpsf_pkg::DPSF_ST_WSET
                                || state_reg == dpsf_pkg::DPSF_ST_RSET
                                || (state_reg == dpsf_pkg::DPSF_ST_WSTB && !tmr_done)
                                || (state_reg == dpsf_pkg::DPSF_ST_RSTB && !tmr_done));
      // rising rw ends the strobe, where the write lands
      rw_n_o <= !(state_reg == dpsf_pkg::DPSF_ST_WSET
                 || (state_reg == dpsf_pkg::DPSF_ST_WSTB && !tmr_done));
      oe_n_o <= !(state_reg == dpsf_pkg::DPSF_ST_RSET
                 || (state_reg == dpsf_pkg::DPSF_ST_RSTB && !tmr_done));
      // upper address lines zero, index on the low three
      addr_o <= {{(`DPSF_ADDR_W-`DPSF_IDX_W){1'b0}}, idx_reg};
      // value on bit zero, the rest copied since the device ignores them
      data_o <= wval_reg ? `DPSF_ALL_ONES : `DPSF_ZERO_BYTE;
      data_oe_n_o <= !(state_reg == dpsf_pkg::DPSF_ST_WSET
                      || (state_reg == dpsf_pkg::DPSF_ST_WSTB && !tmr_done));
    end
  end

  // ----------------------------------------
  // response
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rsp_valid_o <= 1'b0;
      rsp_owned_o <= 1'b0;
    end else begin
      rsp_valid_o <= (state_reg == dpsf_pkg::DPSF_ST_GAP) && tmr_done
                     && (op_reg != dpsf_pkg::DPSF_OP_INIT || last_init);
      // sample at strobe end; active-low flag, zero means owned
      if (state_reg == dpsf_pkg::DPSF_ST_RSTB && tmr_done) begin
        rsp_owned_o <= !data_i[0];
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_MEM_IDLE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    mem_select_n_o) else $error("memory select asserted");
  AST_ADDR_HIGH: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    addr_o[`DPSF_ADDR_W-1:`DPSF_IDX_W] == '0) else $error("upper address set");
  AST_WR_SEL: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !rw_n_o |-> !flag_space_select_n_o && !data_oe_n_o && oe_n_o)
    else $error("write without select");
  AST_RD_GAP: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    $rose(oe_n_o) |-> flag_space_select_n_o [*2])
    else $error("no gap after read");
  AST_ACQ_ORDER: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (state_reg == dpsf_pkg::DPSF_ST_WSTB && tmr_done
     && op_reg == dpsf_pkg::DPSF_OP_ACQUIRE) |-> ##2 !oe_n_o)
    else $error("acquire lacks read-back");
  AST_REL_DATA: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (!rw_n_o && op_reg != dpsf_pkg::DPSF_OP_ACQUIRE) |-> data_o[0])
    else $error("release writes zero");
  AST_STROBE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    $fell(rw_n_o) |-> !rw_n_o [*3]) else $error("strobe too short");
  AST_POLL_RD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (cmd_ready_o && cmd_valid_i && cmd_op_i == dpsf_pkg::DPSF_OP_POLL)
    |-> ##2 !oe_n_o && rw_n_o) else $error("poll does not read");
  COV_ACQ: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rsp_valid_o && rsp_owned_o && op_reg == dpsf_pkg::DPSF_OP_ACQUIRE);
  COV_FAIL: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rsp_valid_o && !rsp_owned_o && op_reg == dpsf_pkg::DPSF_OP_ACQUIRE);
  COV_INIT: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rsp_valid_o && op_reg == dpsf_pkg::DPSF_OP_INIT);
  COV_REL: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rsp_valid_o && op_reg == dpsf_pkg::DPSF_OP_RELEASE);
endmodule : dpsf_ctrl

/* dpsf_flag_model.sv */
// Purpose: behavioural flag device, left port on the controller, right port on the bench
// Assumes: write lands as the strobe ends, on select or rw rising at the left port, on rw rising at the right port
// Notes:   latches start unknown, as the real part has no power-up value
`timescale 1ns/100ps
module dpsf_flag_model (
  // left port
  input  wire logic        l_mem_n_i,
  input  wire logic        l_sem_n_i,
  input  wire logic        l_rw_n_i,
  input  wire logic        l_oe_n_i,
  input  wire logic [12:0] l_addr_i,
  input  wire logic [7:0]  l_data_i,
  output logic      [7:0]  l_data_o,
  // right port
  input  wire logic        r_sem_n_i,
  input  wire logic        r_rw_n_i,
  input  wire logic        r_oe_n_i,
  input  wire logic [2:0]  r_idx_i,
  input  wire logic        r_d0_i,
  output logic      [7:0]  r_data_o
);
  // ----------------------------------------
  // latches
  // ----------------------------------------
  // no wait or gating output: flags only hold state
  logic [7:0] req [2];  // eight flags apart from memory
  logic [7:0] own [2];  // unknown until written
  logic [7:0] q_l;
  logic [7:0] q_r;
  logic       l_rd_n;
  logic       r_rd_n;
  logic       l_wr_n;
  logic       l_wr_armed = 1'b0;
  assign l_rd_n = l_sem_n_i | l_oe_n_i | ~l_mem_n_i;
  assign l_wr_n = l_sem_n_i | l_rw_n_i | ~l_mem_n_i;
  assign r_rd_n = r_sem_n_i | r_oe_n_i;
  task automatic wr(input int s, input logic [2:0] i, input logic v);
    req[s][i] = v;
    if (!v && own[1-s][i] !== 1'b1) begin
      own[s][i] = 1'b1;  // first request takes the token
    end else if (v) begin
      if (own[s][i] !== 1'b0) begin
        own[1-s][i] = ~req[1-s][i];  // hand over to a pending request
      end
      own[s][i] = 1'b0;
    end
    // a non-owner zero just waits in req
  endtask : wr
  // ----------------------------------------
  // port activity
  // ----------------------------------------
  // select and rw may rise together, so the strobe ends on whichever rises first
  // arming on the falling edge keeps the power-up rise from posing as a write
  always @(negedge l_wr_n) l_wr_armed = 1'b1;
  always @(posedge l_wr_n) if (l_wr_armed) begin
    l_wr_armed = 1'b0;
    wr(0, l_addr_i[2:0], l_data_i[0]);
  end
  always @(posedge r_rw_n_i) if (!r_sem_n_i) wr(1, r_idx_i, r_d0_i);
  always @(negedge l_rd_n) q_l = {8{~own[0][l_addr_i[2:0]]}};
  always @(negedge r_rd_n) q_r = {8{~own[1][r_idx_i]}};
  // released bus shows the inverse, never a stale copy
  assign l_data_o = (!l_rd_n && l_rw_n_i) ? q_l : ~q_l;
  assign r_data_o = (!r_rd_n && r_rw_n_i) ? q_r : ~q_r;
endmodule : dpsf_flag_model

/* dpsf_ctrl_test.sv */
// Purpose: self-checking bench for the flag port controller
// Assumes: bench drives the far port of the flag model by hand
// Notes:   inputs change 2 ns after the rising edge
`timescale 1ns/100ps
module dpsf_ctrl_test;
  logic ref_clk_i = 1'b0, resetn_i = 1'b0, cmd_valid_i = 1'b0, cmd_ready_o, rsp_valid_o;
  logic rsp_owned_o, mem_n, sem_n, rw_n, oe_n, data_oe_n_o;
  logic r_sem_n = 1'b1, r_rw_n = 1'b1, r_oe_n = 1'b1, r_d0 = 1'b1;
  logic [2:0] cmd_idx_i = 3'h0, r_idx = 3'h0;
  logic [12:0] addr;
  logic [7:0] data_o, l_q, r_q;
  dpsf_pkg::dpsf_op_type cmd_op_i = dpsf_pkg::DPSF_OP_POLL;
  int fail_count = 0, samples_checked = 0, cycles = 0;
  initial forever #25 ref_clk_i = ~ref_clk_i;
  dpsf_ctrl dut_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i), .cmd_idx_i(cmd_idx_i), .cmd_ready_o(cmd_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_owned_o(rsp_owned_o), .mem_select_n_o(mem_n),
    .flag_space_select_n_o(sem_n), .rw_n_o(rw_n), .oe_n_o(oe_n), .addr_o(addr),
    .data_o(data_o), .data_oe_n_o(data_oe_n_o), .data_i(l_q));
  dpsf_flag_model dev_u (.l_mem_n_i(mem_n), .l_sem_n_i(sem_n), .l_rw_n_i(rw_n), .l_oe_n_i(oe_n),
    .l_addr_i(addr), .l_data_i(data_o), .l_data_o(l_q), .r_sem_n_i(r_sem_n),
    .r_rw_n_i(r_rw_n), .r_oe_n_i(r_oe_n), .r_idx_i(r_idx), .r_d0_i(r_d0), .r_data_o(r_q));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #2;
  endtask : tick
  task automatic cmd(input dpsf_pkg::dpsf_op_type op, input logic [2:0] i,
                     input logic exp_own, input logic chk);
    int n;
    n = 0;
    cmd_op_i = op;
    cmd_idx_i = i;
    cmd_valid_i = 1'b1;
    tick(1);
    cmd_valid_i = 1'b0;
    while (rsp_valid_o !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    if (n >= 400) check(8'h01, 8'h00);
    check({7'h00, cmd_ready_o}, 8'h01);
    if (chk) check({7'h00, rsp_owned_o}, {7'h00, exp_own});
  endtask : cmd
  // far port write; the strobe stays low two cycles so the write lands on its rise
  task automatic rwr(input logic [2:0] i, input logic v);
    r_idx = i;
    r_d0 = v;
    r_sem_n = 1'b0;
    r_rw_n = 1'b0;
    tick(2);
    r_rw_n = 1'b1;
    tick(1);
    r_sem_n = 1'b1;
    tick(1);
  endtask : rwr
  task automatic rrd(input logic [2:0] i, input logic v);
    r_idx = i;
    r_sem_n = 1'b0;
    r_oe_n = 1'b0;
    tick(1);
    check(r_q, {8{v}});
    r_oe_n = 1'b1;
    r_sem_n = 1'b1;
    tick(1);
  endtask : rrd
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic sc_init();
    cmd(dpsf_pkg::DPSF_OP_INIT, 3'h0, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) rwr(3'(i), 1'b1);
    for (int i = 0; i < 8; i++) rrd(3'(i), 1'b1);
  endtask : sc_init
  // hand-over with the far read frozen across the change
  task automatic sc_handover();
    cmd(dpsf_pkg::DPSF_OP_ACQUIRE, 3'h5, 1'b1, 1'b1);
    rrd(3'h5, 1'b1);
    rwr(3'h5, 1'b0);
    rrd(3'h5, 1'b1);
    r_idx = 3'h5;
    r_sem_n = 1'b0;
    r_oe_n = 1'b0;
    tick(1);
    cmd(dpsf_pkg::DPSF_OP_RELEASE, 3'h5, 1'b0, 1'b0);
    check(r_q, 8'hff);
    r_sem_n = 1'b1;
    r_oe_n = 1'b1;
    tick(1);
    rrd(3'h5, 1'b0);
    cmd(dpsf_pkg::DPSF_OP_POLL, 3'h5, 1'b0, 1'b1);
    rwr(3'h5, 1'b1);
    rrd(3'h5, 1'b1);
    cmd(dpsf_pkg::DPSF_OP_POLL, 3'h5, 1'b0, 1'b1);
  endtask : sc_handover
  // failed request withdrawn, so the flag is free once the far side lets go
  task automatic sc_withdraw();
    rwr(3'h2, 1'b0);
    cmd(dpsf_pkg::DPSF_OP_ACQUIRE, 3'h2, 1'b0, 1'b1);
    cmd(dpsf_pkg::DPSF_OP_RELEASE, 3'h2, 1'b0, 1'b0);
    rwr(3'h2, 1'b1);
    cmd(dpsf_pkg::DPSF_OP_POLL, 3'h2, 1'b0, 1'b1);
    rrd(3'h2, 1'b1);
    rwr(3'h2, 1'b0);
    rrd(3'h2, 1'b0);
    rwr(3'h2, 1'b1);
  endtask : sc_withdraw
  task automatic sc_all_flags();
    for (int i = 0; i < 8; i++) begin
      cmd(dpsf_pkg::DPSF_OP_ACQUIRE, 3'(i), 1'b1, 1'b1);
      rrd(3'(i), 1'b1);
      cmd(dpsf_pkg::DPSF_OP_RELEASE, 3'(i), 1'b0, 1'b0);
      rrd(3'(i), 1'b1);
    end
  endtask : sc_all_flags
  initial begin
    tick(16);
    resetn_i = 1'b1;
    tick(1);
    sc_init();
    sc_handover();
    sc_withdraw();
    sc_all_flags();
    tally_and_finish();
  end
endmodule : dpsf_ctrl_test
